// ==== hdl/fpl_load_unit.sv ====
`timescale 1ns/1ps
module fpl_load_unit (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic issue_valid_i,
    input fpl_pkg::fpl_issue_type issue_i,
    output logic issue_ready_o,
    output logic mem_req_valid_o,
    output fpl_pkg::fpl_mem_req_type mem_req_o,
    input wire logic mem_req_ready_i,
    input wire logic mem_rsp_valid_i,
    input wire logic [63:0] mem_rsp_data_i,
    output logic fpr_wr_en_o,
    output fpl_pkg::fpl_fpr_wr_type fpr_wr_o,
    output logic gpr_wr_en_o,
    output fpl_pkg::fpl_gpr_wr_type gpr_wr_o,
    output logic done_o,
    output fpl_pkg::fpl_status_type status_o
);
    import fpl_pkg::*;

    fpl_state_type state_q;
    logic [5:0] opc;
    logic [9:0] xo;
    logic [4:0] base_reg_field;
    logic [4:0] float_target_field;
    logic record_flag;
    logic is_xform;
    logic is_load;
    logic is_store;
    logic is_update;
    logic is_single;
    logic bad_form;
    logic [31:0] disp_ext;
    logic [31:0] base_term;
    logic [31:0] ea_d;
    logic accept;
    logic single_q;
    logic update_q;
    logic [4:0] base_q;
    logic [4:0] target_q;
    logic [31:0] ea_q;
    logic [63:0] fpr_data_q;
    logic done_q;
    fpl_status_type status_q;

    function automatic logic [63:0] widen(input logic [31:0] w);
        logic [10:0] e;
        logic [51:0] f;
        logic [4:0] k;
        logic [22:0] m;
        e = '0;
        f = '0;
        k = '0;
        m = w[22:0];
        if (w[30:23] == SP_EXP_ALL_ONES) begin
            e = EXP_ALL_ONES;
            f = {w[22:0], FRAC_PAD};
        end else if (w[30:23] != 8'h00) begin
            e = {3'b000, w[30:23]} + EXP_BIAS_ADJ;
            f = {w[22:0], FRAC_PAD};
        end else if (m != 23'h00_0000) begin
            // denormal single: normalise, leading one drops out of the fraction
            for (int i = 0; i < 23; i++) begin
                if (m[i]) begin
                    k = 5'(i);
                end
            end
            e = {6'b00_0000, k} + DENORM_EXP_BASE;
            m = m << (SP_FRAC_BITS - k);
            f = {m, FRAC_PAD};
        end
        return {w[31], e, f};
    endfunction

    assign opc = issue_i.instr[OPC_MSB:OPC_LSB];
    assign xo = issue_i.instr[XO_MSB:XO_LSB];
    assign base_reg_field = issue_i.instr[BASE_MSB:BASE_LSB];
    assign float_target_field = issue_i.instr[TGT_MSB:TGT_LSB];
    assign record_flag = issue_i.instr[RECORD_BIT];
    assign is_xform = (opc == OPC_XFORM);

    always_comb begin
        is_load = 1'b0;
        is_store = 1'b0;
        is_update = 1'b0;
        is_single = 1'b0;
        case (opc)
            OPC_LD_SINGLE: begin
                is_load = 1'b1;
                is_single = 1'b1;
            end
            OPC_LD_SINGLE_UPD: begin
                is_load = 1'b1;
                is_single = 1'b1;
                is_update = 1'b1;
            end
            OPC_LD_DOUBLE: begin
                is_load = 1'b1;
            end
            OPC_LD_DOUBLE_UPD: begin
                is_load = 1'b1;
                is_update = 1'b1;
            end
            OPC_ST_SINGLE, OPC_ST_DOUBLE: begin
                is_store = 1'b1;
            end
            OPC_ST_SINGLE_UPD, OPC_ST_DOUBLE_UPD: begin
                is_store = 1'b1;
                is_update = 1'b1;
            end
            OPC_XFORM: begin
                case (xo)
                    XO_LD_SINGLE: begin
                        is_load = 1'b1;
                        is_single = 1'b1;
                    end
                    XO_LD_SINGLE_UPD: begin
                        is_load = 1'b1;
                        is_single = 1'b1;
                        is_update = 1'b1;
                    end
                    XO_LD_DOUBLE: begin
                        is_load = 1'b1;
                    end
                    XO_LD_DOUBLE_UPD: begin
                        is_load = 1'b1;
                        is_update = 1'b1;
                    end
                    // stores are only screened here, no status bit is consulted
                    XO_ST_SINGLE, XO_ST_DOUBLE, XO_ST_INT_WORD: begin
                        is_store = 1'b1;
                    end
                    XO_ST_SINGLE_UPD, XO_ST_DOUBLE_UPD: begin
                        is_store = 1'b1;
                        is_update = 1'b1;
                    end
                    default: begin
                        is_load = 1'b0;
                    end
                endcase
            end
            default: begin
                is_load = 1'b0;
            end
        endcase
    end

    // update with zero base; record flag on indexed forms
    assign bad_form = (is_update && (base_reg_field == 5'h00)) || (is_xform && record_flag && (is_load || is_store));

    assign disp_ext = {{16{issue_i.instr[DISP_MSB]}}, issue_i.instr[DISP_MSB:0]};

    // zero substitution only for non-update forms; update uses real base
    assign base_term = (!is_update && (base_reg_field == 5'h00)) ? 32'h0000_0000 : issue_i.base_value;

    // indexed sum, otherwise base plus displacement
    assign ea_d = base_term + (is_xform ? issue_i.index_value : disp_ext);

    assign accept = (state_q == ST_IDLE) && issue_valid_i;
    assign issue_ready_o = (state_q == ST_IDLE);
    assign mem_req_valid_o = (state_q == ST_REQ);
    assign fpr_wr_en_o = (state_q == ST_WB);
    // base write-back alongside the float register write
    assign gpr_wr_en_o = (state_q == ST_WB) && update_q;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept && is_load && !bad_form) begin
                        state_q <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (mem_req_ready_i) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (mem_rsp_valid_i) begin
                        state_q <= ST_WB;
                    end
                end
                ST_WB: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            single_q <= 1'b0;
            update_q <= 1'b0;
            base_q <= '0;
            target_q <= '0;
            ea_q <= '0;
        end else if (accept) begin
            single_q <= is_single;
            update_q <= is_update;
            base_q <= base_reg_field;
            target_q <= float_target_field;
            ea_q <= ea_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            fpr_data_q <= '0;
        end else if ((state_q == ST_WAIT) && mem_rsp_valid_i) begin
            fpr_data_q <= single_q ? widen(mem_rsp_data_i[31:0]) : mem_rsp_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            done_q <= 1'b0;
            status_q <= '0;
        end else begin
            done_q <= (accept && (bad_form || !is_load)) || (state_q == ST_WB);
            if (accept) begin
                status_q.invalid <= bad_form;
                status_q.unsupported <= !bad_form && !is_load;
            end
        end
    end

    assign mem_req_o.addr = ea_q;
    assign mem_req_o.dword = !single_q;
    assign fpr_wr_o.addr = target_q;
    assign fpr_wr_o.data = fpr_data_q;
    assign gpr_wr_o.addr = base_q;
    assign gpr_wr_o.data = ea_q;
    assign done_o = done_q;
    assign status_o = status_q;

    a_indexed_sum: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        accept && is_load && !bad_form && is_xform && (base_reg_field != 5'h00)
        |=> mem_req_o.addr == $past(issue_i.base_value) + $past(issue_i.index_value))
        else $error("indexed address is not base plus index");

    a_zero_base: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        accept && is_load && !is_update && is_xform && (base_reg_field == 5'h00)
        |=> mem_req_o.addr == $past(issue_i.index_value))
        else $error("zero base not substituted");

    a_update_zero_bad: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        accept && is_update && (base_reg_field == 5'h00)
        |=> done_o && status_o.invalid && (state_q == ST_IDLE))
        else $error("update form with zero base not rejected");

    a_record_bad: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        accept && is_xform && record_flag && (is_load || is_store)
        |=> done_o && status_o.invalid && !mem_req_valid_o)
        else $error("record flag form not rejected");

    a_single_widen: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (state_q == ST_WAIT) && mem_rsp_valid_i && single_q
        && (mem_rsp_data_i[30:23] != 8'h00) && (mem_rsp_data_i[30:23] != SP_EXP_ALL_ONES)
        |=> fpr_wr_en_o && (fpr_wr_o.data[63] == $past(mem_rsp_data_i[31]))
        && (fpr_wr_o.data[62:52] == {3'b000, $past(mem_rsp_data_i[30:23])} + EXP_BIAS_ADJ))
        else $error("single operand not widened");

    a_word_fetch: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        accept && is_load && !bad_form && is_single
        |=> mem_req_valid_o && !mem_req_o.dword)
        else $error("single load did not fetch a word");

    a_double_pass: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (state_q == ST_WAIT) && mem_rsp_valid_i && !single_q
        |=> fpr_wr_en_o && (fpr_wr_o.data == $past(mem_rsp_data_i)))
        else $error("double operand altered");

    a_update_wb: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        fpr_wr_en_o && update_q |-> gpr_wr_en_o && (gpr_wr_o.data == mem_req_o.addr)
        && (gpr_wr_o.addr == base_q))
        else $error("update load lost its base write-back");

    a_update_disp: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        accept && is_load && is_update && !is_xform && !bad_form
        |=> mem_req_o.addr == $past(issue_i.base_value)
        + {{16{$past(issue_i.instr[DISP_MSB])}}, $past(issue_i.instr[DISP_MSB:0])})
        else $error("update displacement address wrong");

    a_update_index: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        accept && is_load && is_update && is_xform && !bad_form
        |=> mem_req_o.addr == $past(issue_i.base_value) + $past(issue_i.index_value))
        else $error("update indexed address wrong");

    a_disp_sext: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        accept && is_load && !is_xform && (base_reg_field == 5'h00) && !bad_form
        |=> mem_req_o.addr == {{16{$past(issue_i.instr[DISP_MSB])}}, $past(issue_i.instr[DISP_MSB:0])})
        else $error("displacement not sign-extended");

    a_decode_double: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        accept && (opc == OPC_LD_DOUBLE) |=> mem_req_valid_o && mem_req_o.dword ##0 !status_o.unsupported)
        else $error("double load not decoded");

    c_single_load: cover property (@(posedge clock_i) disable iff (sys_rst_i)
        fpr_wr_en_o && single_q && !update_q);
    c_double_update: cover property (@(posedge clock_i) disable iff (sys_rst_i)
        fpr_wr_en_o && !single_q && gpr_wr_en_o);
    c_invalid_form: cover property (@(posedge clock_i) disable iff (sys_rst_i)
        done_o && status_o.invalid);
    c_req_stall: cover property (@(posedge clock_i) disable iff (sys_rst_i)
        mem_req_valid_o && !mem_req_ready_i ##1 mem_req_valid_o && mem_req_ready_i);

endmodule

// ==== hdl/fpl_pkg.sv ====
package fpl_pkg;

    // primary opcodes, instruction bits 0..5 (big-endian numbering)
    localparam logic [5:0] OPC_LD_SINGLE = 6'h30;
    localparam logic [5:0] OPC_LD_SINGLE_UPD = 6'h31;
    localparam logic [5:0] OPC_LD_DOUBLE = 6'h32;
    localparam logic [5:0] OPC_LD_DOUBLE_UPD = 6'h33;
    localparam logic [5:0] OPC_ST_SINGLE = 6'h34;
    localparam logic [5:0] OPC_ST_SINGLE_UPD = 6'h35;
    localparam logic [5:0] OPC_ST_DOUBLE = 6'h36;
    localparam logic [5:0] OPC_ST_DOUBLE_UPD = 6'h37;
    localparam logic [5:0] OPC_XFORM = 6'h1F;

    // extended opcodes of the indexed forms
    localparam logic [9:0] XO_LD_SINGLE = 10'h217;
    localparam logic [9:0] XO_LD_SINGLE_UPD = 10'h237;
    localparam logic [9:0] XO_LD_DOUBLE = 10'h257;
    localparam logic [9:0] XO_LD_DOUBLE_UPD = 10'h277;
    localparam logic [9:0] XO_ST_SINGLE = 10'h297;
    localparam logic [9:0] XO_ST_SINGLE_UPD = 10'h2B7;
    localparam logic [9:0] XO_ST_DOUBLE = 10'h2D7;
    localparam logic [9:0] XO_ST_DOUBLE_UPD = 10'h2F7;
    localparam logic [9:0] XO_ST_INT_WORD = 10'h3D7;

    // field positions in the 32-bit instruction word (bit 0 = lsb here)
    localparam int OPC_MSB = 31;
    localparam int OPC_LSB = 26;
    localparam int TGT_MSB = 25;
    localparam int TGT_LSB = 21;
    localparam int BASE_MSB = 20;
    localparam int BASE_LSB = 16;
    localparam int XO_MSB = 10;
    localparam int XO_LSB = 1;
    localparam int DISP_MSB = 15;
    localparam int RECORD_BIT = 0;

    // single to double widening
    localparam logic [10:0] EXP_BIAS_ADJ = 11'h380;
    localparam logic [10:0] DENORM_EXP_BASE = 11'h36A;
    localparam logic [10:0] EXP_ALL_ONES = 11'h7FF;
    localparam logic [7:0] SP_EXP_ALL_ONES = 8'hFF;
    localparam logic [4:0] SP_FRAC_BITS = 5'h17;
    localparam logic [28:0] FRAC_PAD = 29'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_WAIT = 2'b11,
        ST_WB = 2'b10
    } fpl_state_type;

    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] base_value;
        logic [31:0] index_value;
    } fpl_issue_type;

    typedef struct packed {
        logic [31:0] addr;
        logic dword;
    } fpl_mem_req_type;

    typedef struct packed {
        logic [4:0] addr;
        logic [63:0] data;
    } fpl_fpr_wr_type;

    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] data;
    } fpl_gpr_wr_type;

    typedef struct packed {
        logic invalid;
        logic unsupported;
    } fpl_status_type;

endpackage

// ==== tb/fpl_mem_model.sv ====
`timescale 1ns/1ps
module fpl_mem_model (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic mem_req_valid_i,
    input fpl_pkg::fpl_mem_req_type mem_req_i,
    output logic mem_req_ready_o,
    output logic mem_rsp_valid_o,
    output logic [63:0] mem_rsp_data_o,
    input wire logic [63:0] rd_data_i,
    input wire logic [2:0] ready_delay_i,
    input wire logic [2:0] rsp_delay_i,
    output logic [31:0] req_addr_o,
    output logic req_dword_o,
    output logic [15:0] req_count_o
);
    import fpl_pkg::*;

    initial begin
        mem_req_ready_o = 1'b0;
        mem_rsp_valid_o = 1'b0;
        mem_rsp_data_o = 64'h0000_0000_0000_0000;
        req_addr_o = 32'h0000_0000;
        req_dword_o = 1'b0;
        req_count_o = 16'h0000;
    end

    // one request at a time: stall, accept, then answer after a delay
    always begin
        @(negedge clock_i);
        if (mem_req_valid_i === 1'b1 && sys_rst_i === 1'b0) begin
            repeat (ready_delay_i) @(negedge clock_i);
            req_addr_o = mem_req_i.addr;
            req_dword_o = mem_req_i.dword;
            req_count_o = req_count_o + 16'h0001;
            mem_req_ready_o = 1'b1;
            @(posedge clock_i);
            @(negedge clock_i);
            mem_req_ready_o = 1'b0;
            repeat (rsp_delay_i) @(negedge clock_i);
            // a word answer sits in the low half, the high half carries junk
            mem_rsp_valid_o = 1'b1;
            mem_rsp_data_o = rd_data_i;
            @(negedge clock_i);
            mem_rsp_valid_o = 1'b0;
            // released data line shows the inverse, never a stale copy
            mem_rsp_data_o = ~mem_rsp_data_o;
        end
    end
endmodule

// ==== tb/test_fpl_load_address_and_format.sv ====
`timescale 1ns/1ps
module test_fpl_load_address_and_format;
    import fpl_pkg::*;
    logic clock_i = 1'b0;
    logic sys_rst_i;
    logic issue_valid_i;
    fpl_issue_type issue_i;
    logic issue_ready_o, mem_req_valid_o, mem_req_ready_i, mem_rsp_valid_i;
    fpl_mem_req_type mem_req_o;
    logic [63:0] mem_rsp_data_i, rd_data;
    logic fpr_wr_en_o, gpr_wr_en_o, done_o;
    fpl_fpr_wr_type fpr_wr_o;
    fpl_gpr_wr_type gpr_wr_o;
    fpl_status_type status_o;
    logic [2:0] rdly, sdly;
    logic [31:0] req_addr, ins, r;
    logic req_dword;
    logic [15:0] req_count;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int seed, n, kind;

    always #20 clock_i = ~clock_i;

    fpl_load_unit DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .issue_valid_i(issue_valid_i),
        .issue_i(issue_i), .issue_ready_o(issue_ready_o), .mem_req_valid_o(mem_req_valid_o),
        .mem_req_o(mem_req_o), .mem_req_ready_i(mem_req_ready_i), .mem_rsp_valid_i(mem_rsp_valid_i),
        .mem_rsp_data_i(mem_rsp_data_i), .fpr_wr_en_o(fpr_wr_en_o), .fpr_wr_o(fpr_wr_o),
        .gpr_wr_en_o(gpr_wr_en_o), .gpr_wr_o(gpr_wr_o), .done_o(done_o), .status_o(status_o));

    fpl_mem_model MEM (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .mem_req_valid_i(mem_req_valid_o),
        .mem_req_i(mem_req_o), .mem_req_ready_o(mem_req_ready_i), .mem_rsp_valid_o(mem_rsp_valid_i),
        .mem_rsp_data_o(mem_rsp_data_i), .rd_data_i(rd_data), .ready_delay_i(rdly), .rsp_delay_i(sdly),
        .req_addr_o(req_addr), .req_dword_o(req_dword), .req_count_o(req_count));

    task automatic results;
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // reference single to double widening, denormals normalised
    function automatic logic [63:0] widen(input logic [31:0] w);
        int e;
        int p;
        e = w[30:23];
        p = 22;
        if (e == 255) return {w[31], 11'h7FF, w[22:0], 29'h0000_0000};
        if (e != 0) return {w[31], 11'(e + 896), w[22:0], 29'h0000_0000};
        if (w[22:0] == 23'h00_0000) return {w[31], 63'h0};
        while (w[p] == 1'b0) p--;
        return {w[31], 11'(p + 874), 52'({41'h0, w[22:0]} << (52 - p))};
    endfunction

    task automatic run_one(input logic [31:0] bv, input logic [31:0] iv);
        int opc, xo, base, k, i, cnt;
        bit xf, ld, st, upd, dw, inv, uns, go;
        logic [31:0] ea;
        logic [63:0] exp_fpr;
        opc = ins[31:26];
        xo = ins[10:1];
        base = ins[20:16];
        xf = (opc == 31);
        k = xf ? (xo / 32) % 4 : opc % 4;
        ld = xf ? (xo % 32 == 23 && xo / 128 == 4) : (opc >= 48 && opc <= 51);
        st = xf ? ((xo % 32 == 23 && xo / 128 == 5) || xo == 983) : (opc >= 52 && opc <= 55);
        upd = (ld || st) && k % 2 == 1;
        dw = k >= 2;
        inv = (upd && base == 0) || (xf && ins[0] && (ld || st));
        uns = !inv && !ld;
        go = !inv && ld;
        ea = (base == 0 && !upd) ? 32'h0000_0000 : bv;
        ea = ea + (xf ? iv : {{16{ins[15]}}, ins[15:0]});
        exp_fpr = dw ? rd_data : widen(rd_data[31:0]);
        cnt = req_count;
        issue_i = {ins, bv, iv};
        issue_valid_i = 1'b1;
        i = 0;
        while (issue_ready_o !== 1'b1 && i < 50) begin
            @(negedge clock_i);
            i++;
        end
        @(posedge clock_i);
        @(negedge clock_i);
        issue_valid_i = 1'b0;
        chk(mem_req_valid_o === go, "request launch");
        if (go) chk(issue_ready_o === 1'b0, "busy still takes issue");
        i = 0;
        // a load writes back one cycle before its completion pulse
        while (fpr_wr_en_o !== 1'b1 && done_o !== 1'b1 && i < 100) begin
            @(negedge clock_i);
            i++;
        end
        chk(fpr_wr_en_o === go, "float write enable");
        if (go) chk(req_addr === ea && req_dword === dw, "address or size");
        if (go) chk(fpr_wr_o === {ins[25:21], exp_fpr}, "float data");
        chk(gpr_wr_en_o === (go && upd), "base write enable");
        if (go && upd) chk(gpr_wr_o === {ins[20:16], ea}, "base write data");
        if (go) @(negedge clock_i);
        chk(done_o === 1'b1, "no completion");
        chk(status_o === {inv, uns}, "status");
        chk(req_count === 16'(cnt + int'(go)), "memory request count");
        @(negedge clock_i);
        chk(issue_ready_o === 1'b1 && done_o === 1'b0, "not free again");
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("mismatch at %0t: timeout", $time);
            results;
        end
    end

    initial begin
        seed = 32'ha37d_1d7b;
        sys_rst_i = 1'b1;
        issue_valid_i = 1'b0;
        issue_i = '0;
        rd_data = 64'h0000_0000_0000_0000;
        rdly = 3'h0;
        sdly = 3'h0;
        repeat (20) @(negedge clock_i);
        sys_rst_i = 1'b0;
        chk(issue_ready_o === 1'b1 && mem_req_valid_o === 1'b0 && done_o === 1'b0, "reset state");
        for (n = 0; n < 400; n++) begin
            kind = n < 24 ? n % 12 : $unsigned($random(seed)) % 12;
            r = $random(seed);
            ins = $random(seed);
            if (r[1:0] == 2'b00) ins[20:16] = 5'h00;
            if (kind < 4) ins[31:26] = OPC_LD_SINGLE + 6'(kind);
            else if (kind < 8) ins[31:26] = OPC_XFORM;
            else if (kind == 8) ins[31:26] = OPC_ST_SINGLE + 6'(r[5:4]);
            else if (kind == 9) ins[31:26] = OPC_XFORM;
            else if (kind == 10) ins[31:26] = 6'(r[8:6]);
            else ins[31:26] = OPC_XFORM;
            if (kind >= 4 && kind < 8) ins[10:1] = XO_LD_SINGLE + 10'(32 * (kind - 4));
            if (kind == 9) ins[10:1] = r[6] ? XO_ST_INT_WORD : XO_ST_SINGLE + 10'(32 * r[5:4]);
            if (kind == 11) ins[10:1] = {r[15:11], 5'h16};
            if (ins[31:26] == OPC_XFORM) ins[0] = (r[3:2] == 2'b00);
            rd_data = {$random(seed), $random(seed)};
            if (r[10:9] == 2'b00) rd_data[30:23] = 8'h00;
            if (r[10:9] == 2'b01) rd_data[30:23] = 8'hFF;
            if (r[13]) rd_data[22:12] = 11'h000;
            rdly = r[18:16];
            sdly = r[21:19];
            run_one($random(seed), $random(seed));
        end
        results;
    end
endmodule
